// File: rtl/pbw_cfg.svh
`ifndef PBW_CFG_SVH
`define PBW_CFG_SVH

// Configuration register offsets
`define PBW_CHIP_CTRL_OFS 8'h44
`define PBW_MWI_CTRL_OFS  8'h74
`define PBW_DRC_OFS       8'h88
`define PBW_STATUS_OFS    8'hF0

// Field positions
`define PBW_MWDC_BIT      1
`define PBW_MWI_HI        8
`define PBW_MWI_LO        7
`define PBW_STAT_SERR     0

// Reset values
`define PBW_CHIP_CTRL_RST 32'h0000_0000
`define PBW_MWI_CTRL_RST  32'h0000_0000
`define PBW_DRC_RST       32'h0000_8000

// Counts
`define PBW_RETRY_LIMIT   33'h0_0100_0000
`define PBW_DEVSEL_WAIT   3'h5
`define PBW_PAGE_END      10'h3FF

`endif

// File: rtl/pbw_pkg.sv
package pbw_pkg;

  // Bus command codes used by the write path
  typedef enum logic [3:0] {
    PBW_IO_WR  = 4'h3,
    PBW_MEM_WR = 4'h7,
    PBW_CFG_WR = 4'hB,
    PBW_MWI    = 4'hF
  } pbw_cmd_e;

  // Target side states, all eight codes used
  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_DEC   = 3'b001,
    T_CLAIM = 3'b010,
    T_POST  = 3'b011,
    T_DLY   = 3'b100,
    T_DCOMP = 3'b101,
    T_STOPW = 3'b110,
    T_TURN  = 3'b111
  } pbw_tst_e;

  // Master side states
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_ADDR = 3'b001,
    M_DATA = 3'b010,
    M_DROP = 3'b011,
    M_TURN = 3'b100
  } pbw_mst_e;

  // Posted queue entry: an address word or a data word
  typedef struct packed {
    logic        is_addr;
    logic [3:0]  cmd;
    logic [31:0] data;
    logic [3:0]  be;
  } pbw_pw_s;

  // Delayed write queue entry
  typedef struct packed {
    logic        valid;
    logic        done;
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
    logic        apar;
    logic        dpar;
  } pbw_dq_s;

endpackage

// File: rtl/pbw_bridge.sv
`timescale 1ns/10ps
`include "pbw_cfg.svh"
// How it works
// R1 - Nonzero low address bits: disconnect after the first data transfer.
// R2 - Claim only by positive decode at medium devsel, never subtractive.
// R3 - Data moves on IRDY and TRDY; IRDY with STOP also ends a phase.
// R4 - Memory writes posted; VGA, I/O and type 1 config writes delayed.
// R5 - Posted write: devsel medium, TRDY next clock, only with queue room.
// R6 - Posted data taken one word per clock, no waits, no bus needed.
// R7 - Accept until initiator ends; boundary or full gives a disconnect.
// R8 - Request target bus at queue head; FRAME with address, data next.
// R9 - One word per clock as master; empty queue ends, follow-on later.
// R10 - Done, disconnect, retry, abort or latency expiry end the master.
// R11 - MWI control 11 disconnects at lines; 00 reissues as memory write.
// R12 - Delayed writes carry one word and disconnect after it.
// R13 - New delayed write: claim, retry, capture command, address, data.
// R14 - Enqueue only without an entry of same command, address, enables and enabled data, if free.
// R15 - Issue head delayed write after posted data; repeat on retry.
// R16 - Retry limit exhausted raises system error, pin if enabled.
// R17 - Matching repeat of head completion gets TRDY, plus STOP if more.
// R18 - Compare only data bytes whose enables are active.
// R19 - Repeats before delivery get retry and no new entry.
// R20 - Discard timer from 88h drops unclaimed completions, error flagged.
// R21 - Memory write boundary: 4KB when control bit is 0, line when 1 and line size is 1, 2, 4, 8 or 16.
// R22 - MWI: line size other than 1, 2, 4, 8 or 16 gives 4KB, else line when room is short.
module pbw_bridge
  import pbw_pkg::*;
#(
  parameter int unsigned PW_DEPTH    = 32,
  parameter int unsigned DQ_DEPTH    = 4,
  parameter logic [32:0] RETRY_LIMIT = `PBW_RETRY_LIMIT
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Configuration space access
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  // Bridge level settings
  input  wire logic [7:0]  cache_line_size_i,
  input  wire logic [7:0]  latency_timer_i,
  input  wire logic        serr_enable_i,
  // Initiator bus, bridge as target
  input  wire logic        t_frame_n_i,
  input  wire logic        t_irdy_n_i,
  input  wire logic [31:0] t_ad_i,
  input  wire logic [3:0]  t_cbe_n_i,
  input  wire logic        t_par_i,
  input  wire logic        t_hit_i,
  input  wire logic        t_vga_hit_i,
  output logic             t_devsel_n_o,
  output logic             t_trdy_n_o,
  output logic             t_stop_n_o,
  output logic             t_ctl_oe_o,
  // Target bus, bridge as master
  output logic             m_req_n_o,
  input  wire logic        m_gnt_n_i,
  input  wire logic        m_frame_n_i,
  input  wire logic        m_irdy_n_i,
  input  wire logic        m_trdy_n_i,
  input  wire logic        m_stop_n_i,
  input  wire logic        m_devsel_n_i,
  output logic             m_frame_n_o,
  output logic             m_irdy_n_o,
  output logic             m_ctl_oe_o,
  output logic      [31:0] m_ad_o,
  output logic      [3:0]  m_cbe_n_o,
  output logic             m_ad_oe_o,
  // System error pin, open drain
  output logic             primary_system_error_out_n_o,
  output logic             primary_system_error_out_oe_o
);

  localparam int unsigned PA = $clog2(PW_DEPTH);
  localparam int unsigned QA = $clog2(DQ_DEPTH);

  pbw_tst_e      t_st_ff;
  pbw_mst_e      m_st_ff;
  logic [31:0]   chip_ctrl_ff, mwi_ctrl_ff, drc_ff;
  logic          serr_ff, serr_pin_ff;
  pbw_pw_s       pw_mem [PW_DEPTH];
  pbw_pw_s       pw_in, pw_hd;
  logic [PA-1:0] pw_wp_ff, pw_rp_ff;
  logic [PA:0]   pw_cnt_ff, pw_free;
  logic          pw_push, pw_pop, pw_hd_addr;
  pbw_dq_s       dq_mem [DQ_DEPTH];
  pbw_dq_s       dq_hd;
  logic [QA-1:0] dq_hd_ff, dq_tl_ff, t_hit_ix;
  logic [QA:0]   dq_cnt_ff;
  logic          dq_par_ff, dq_pop, t_match, t_comp, t_enq, t_rel;
  logic          t_frm_q_ff, t_post_ff, t_ok_ff, t_apar_ff, t_take;
  logic          t_is_post, t_is_dly, t_disc, use_line, cls_ok;
  logic [31:0]   t_addr_ff;
  logic [3:0]    t_cmd_ff, cmask;
  logic [31:0]   m_addr_ff, dis_cnt_ff;
  logic [3:0]    m_cmd_ff;
  logic [7:0]    m_lat_ff;
  logic [2:0]    m_dvw_ff;
  logic [32:0]   m_try_ff;
  logic          m_dly_ff, m_frame_ff, dis_run_ff, dis_exp;
  logic          post_rdy, dly_rdy, m_start, xfer, stopped, mabort;
  logic          m_retry, lim_hit, m_drop_dly, serr_evt;

  // True when the k-th posted entry from the head is a data word
  function automatic logic pw_isdat(input int unsigned k);
    pw_isdat = (pw_cnt_ff > (PA+1)'(k)) &&
               !pw_mem[pw_rp_ff + PA'(k)].is_addr;
  endfunction

  // Repeat matches stored entry; disabled bytes are not compared
  function automatic logic dq_same(input pbw_dq_s e);
    logic eq;
    eq = e.valid && e.cmd == t_cmd_ff && e.addr == t_addr_ff &&
         e.be == ~t_cbe_n_i;
    for (int b = 0; b < 4; b++) begin
      if (e.be[b] && e.data[8*b +: 8] != t_ad_i[8*b +: 8]) eq = 1'b0;
    end
    dq_same = eq;
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Configuration registers; the error flag's set wins over a clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chip_ctrl_ff <= `PBW_CHIP_CTRL_RST;
      mwi_ctrl_ff  <= `PBW_MWI_CTRL_RST;
      drc_ff       <= `PBW_DRC_RST;
      serr_ff      <= 1'b0;
      serr_pin_ff  <= 1'b0;
    end else begin
      if (cfg_wr_i && cfg_addr_i == `PBW_CHIP_CTRL_OFS)
        chip_ctrl_ff <= cfg_wdata_i;
      if (cfg_wr_i && cfg_addr_i == `PBW_MWI_CTRL_OFS)
        mwi_ctrl_ff <= cfg_wdata_i;
      if (cfg_wr_i && cfg_addr_i == `PBW_DRC_OFS) drc_ff <= cfg_wdata_i;
      if (serr_evt) begin
        serr_ff <= 1'b1; // see R16 see R20
      end else if (cfg_wr_i && cfg_addr_i == `PBW_STATUS_OFS &&
                   cfg_wdata_i[`PBW_STAT_SERR]) begin
        serr_ff <= 1'b0;
      end
      serr_pin_ff <= serr_evt && serr_enable_i; // see R16
    end
  end

  // Read data; status shows live queue levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
    end else if (cfg_rd_i) begin
      unique case (cfg_addr_i)
        `PBW_CHIP_CTRL_OFS: cfg_rdata_o <= chip_ctrl_ff;
        `PBW_MWI_CTRL_OFS:  cfg_rdata_o <= mwi_ctrl_ff;
        `PBW_DRC_OFS:       cfg_rdata_o <= drc_ff;
        `PBW_STATUS_OFS:    cfg_rdata_o <= {8'h00, 8'(dq_cnt_ff),
                                            8'(pw_cnt_ff), 7'h00, serr_ff};
        default:            cfg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign primary_system_error_out_n_o  = ~serr_pin_ff;
  assign primary_system_error_out_oe_o = serr_pin_ff;

  // Address phase classification and positive decode
  assign t_is_post = (t_cbe_n_i == PBW_MEM_WR && !t_vga_hit_i) ||
                     t_cbe_n_i == PBW_MWI; // see R4
  assign t_is_dly  = (t_cbe_n_i == PBW_MEM_WR && t_vga_hit_i) ||
                     t_cbe_n_i == PBW_IO_WR ||
                     (t_cbe_n_i == PBW_CFG_WR && t_ad_i[1:0] == 2'b01);
  assign t_take = t_st_ff == T_IDLE && !t_frame_n_i && t_frm_q_ff &&
                  t_hit_i && (t_is_post || t_is_dly); // see R2

  // Write boundaries; a 16 dword line wraps the mask to all ones
  assign cls_ok   = cache_line_size_i inside {8'h01, 8'h02, 8'h04,
                                              8'h08, 8'h10};
  assign cmask    = cache_line_size_i[3:0] - 4'h1;
  assign use_line = cls_ok && ((t_cmd_ff == PBW_MWI) ?
                    (mwi_ctrl_ff[`PBW_MWI_HI:`PBW_MWI_LO] == 2'b11 ||
                     pw_free < (PA+1)'(cache_line_size_i)) : // see R11 see R22
                    chip_ctrl_ff[`PBW_MWDC_BIT]);             // see R21
  assign t_disc = t_addr_ff[1:0] != 2'b00 ||                 // see R1
                  pw_free <= (PA+1)'(1) ||                   // see R7
                  (use_line ? (t_addr_ff[5:2] & cmask) == cmask
                            : t_addr_ff[11:2] == `PBW_PAGE_END);

  // Posted queue fill: address at decode, data on each IRDY
  always_comb begin
    pw_push = 1'b0;
    pw_in   = '0;
    if (t_st_ff == T_DEC && t_post_ff && pw_free >= (PA+1)'(2)) begin
      pw_push      = 1'b1; // see R5
      pw_in.is_addr = 1'b1;
      pw_in.data   = t_addr_ff;
      pw_in.cmd    = (t_cmd_ff == PBW_MWI &&
                      mwi_ctrl_ff[`PBW_MWI_HI:`PBW_MWI_LO] == 2'b00) ?
                     PBW_MEM_WR : t_cmd_ff; // see R11
    end else if (t_st_ff == T_POST && !t_irdy_n_i) begin
      pw_push    = 1'b1; // see R3 see R6
      pw_in.data = t_ad_i;
      pw_in.be   = ~t_cbe_n_i;
    end
  end

  // Posted queue pointers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pw_wp_ff  <= '0;
      pw_rp_ff  <= '0;
      pw_cnt_ff <= '0;
    end else begin
      if (pw_push) pw_wp_ff <= pw_wp_ff + 1'b1;
      if (pw_pop) pw_rp_ff <= pw_rp_ff + 1'b1;
      pw_cnt_ff <= pw_cnt_ff + (PA+1)'(pw_push) - (PA+1)'(pw_pop);
    end
  end

  // Posted queue storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (pw_push) pw_mem[pw_wp_ff] <= pw_in;
  end

  assign pw_free = (PA+1)'(PW_DEPTH) - pw_cnt_ff;
  assign pw_hd   = pw_mem[pw_rp_ff];

  // Search delayed queue for a repeat of the current write
  always_comb begin
    t_match  = 1'b0;
    t_hit_ix = '0;
    for (int i = 0; i < DQ_DEPTH; i++) begin
      if (dq_same(dq_mem[i])) begin
        t_match  = 1'b1; // see R14 see R18
        t_hit_ix = QA'(i);
      end
    end
  end

  assign dq_hd  = dq_mem[dq_hd_ff];
  assign t_comp = t_match && t_hit_ix == dq_hd_ff && dq_hd.done; // see R17
  assign t_enq  = t_st_ff == T_DLY && !t_irdy_n_i && !t_match &&
                  dq_cnt_ff < (QA+1)'(DQ_DEPTH); // see R14 see R19
  assign t_rel  = t_st_ff == T_DCOMP && !t_irdy_n_i;

  // Target state machine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      t_st_ff    <= T_IDLE;
      t_addr_ff  <= 32'h0000_0000;
      t_cmd_ff   <= 4'h0;
      t_post_ff  <= 1'b0;
      t_ok_ff    <= 1'b0;
      t_apar_ff  <= 1'b0;
      t_frm_q_ff <= 1'b1;
    end else begin
      t_frm_q_ff <= t_frame_n_i;
      unique case (t_st_ff)
        T_IDLE: if (t_take) begin
          t_addr_ff <= t_ad_i;
          t_cmd_ff  <= t_cbe_n_i;
          t_post_ff <= t_is_post;
          t_st_ff   <= T_DEC;
        end
        T_DEC: begin
          t_apar_ff <= t_par_i; // see R13
          t_ok_ff   <= pw_free >= (PA+1)'(2);
          t_st_ff   <= T_CLAIM;
        end
        T_CLAIM: t_st_ff <= !t_post_ff ? T_DLY :
                            (t_ok_ff ? T_POST : T_STOPW); // see R5
        T_POST: if (!t_irdy_n_i) begin
          t_addr_ff <= t_addr_ff + 32'h0000_0004;
          if (t_frame_n_i) t_st_ff <= T_TURN;
          else if (t_disc) t_st_ff <= T_STOPW; // see R7
        end
        T_DLY: if (!t_irdy_n_i) begin
          t_st_ff <= t_comp ? T_DCOMP : T_STOPW; // see R13 see R19
        end
        T_DCOMP: if (!t_irdy_n_i) begin
          t_st_ff <= t_frame_n_i ? T_TURN : T_STOPW; // see R12
        end
        T_STOPW: if (t_frame_n_i) t_st_ff <= T_TURN;
        T_TURN: t_st_ff <= T_IDLE;
      endcase
    end
  end

  // Target pins; DEVSEL first appears two clocks after the address
  assign t_ctl_oe_o   = t_st_ff != T_IDLE && t_st_ff != T_DEC;
  assign t_devsel_n_o = !(t_ctl_oe_o && t_st_ff != T_TURN);
  assign t_trdy_n_o   = !(t_st_ff == T_POST || t_st_ff == T_DCOMP);
  assign t_stop_n_o   = !(t_st_ff == T_STOPW ||
                          (t_st_ff == T_POST && t_disc) ||
                          (t_st_ff == T_DCOMP && !t_frame_n_i)); // see R17

  // Delayed queue; a drop or completion frees the head entry
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DQ_DEPTH; i++) dq_mem[i] <= '0;
      dq_hd_ff  <= '0;
      dq_tl_ff  <= '0;
      dq_cnt_ff <= '0;
      dq_par_ff <= 1'b0;
    end else begin
      dq_par_ff <= t_enq;
      if (dq_par_ff) dq_mem[dq_tl_ff - 1'b1].dpar <= t_par_i;
      if (t_enq) begin
        dq_mem[dq_tl_ff] <= '{valid: 1'b1, done: 1'b0, cmd: t_cmd_ff,
                              addr: t_addr_ff, data: t_ad_i,
                              be: ~t_cbe_n_i, apar: t_apar_ff,
                              dpar: 1'b0}; // see R13
        dq_tl_ff <= dq_tl_ff + 1'b1;
      end
      if (xfer && m_dly_ff) dq_mem[dq_hd_ff].done <= 1'b1;
      if (dq_pop) begin
        dq_mem[dq_hd_ff].valid <= 1'b0;
        dq_hd_ff <= dq_hd_ff + 1'b1;
      end
      dq_cnt_ff <= dq_cnt_ff + (QA+1)'(t_enq) - (QA+1)'(dq_pop);
    end
  end

  // Discard timer runs while a completion waits at the head
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dis_run_ff <= 1'b0;
      dis_cnt_ff <= 32'h0000_0000;
    end else if (dq_pop) begin
      dis_run_ff <= 1'b0;
    end else if (dq_hd.valid && dq_hd.done) begin
      if (!dis_run_ff) begin
        dis_run_ff <= 1'b1;
        dis_cnt_ff <= drc_ff; // see R20
      end else if (dis_cnt_ff != 32'h0000_0000) begin
        dis_cnt_ff <= dis_cnt_ff - 32'h0000_0001;
      end
    end
  end

  assign dis_exp = dis_run_ff && dis_cnt_ff == 32'h0000_0000 && !t_rel;

  // Master side events
  assign pw_hd_addr = pw_cnt_ff != '0 && pw_hd.is_addr;
  assign post_rdy   = pw_isdat(0);
  assign dly_rdy    = dq_hd.valid && !dq_hd.done && pw_cnt_ff == '0; // see R15
  assign m_start    = m_st_ff == M_IDLE && !pw_hd_addr &&
                      (post_rdy || dly_rdy) && !m_gnt_n_i &&
                      m_frame_n_i && m_irdy_n_i; // see R8
  assign xfer       = m_st_ff == M_DATA && !m_trdy_n_i; // see R3
  assign stopped    = m_st_ff == M_DATA && !m_stop_n_i;
  assign mabort     = m_st_ff == M_DATA && m_devsel_n_i &&
                      m_dvw_ff == `PBW_DEVSEL_WAIT;
  assign m_retry    = stopped && !xfer && !m_devsel_n_i && m_dly_ff;
  assign lim_hit    = m_retry && m_try_ff + 33'h1 >= RETRY_LIMIT; // see R16
  assign m_drop_dly = (m_dly_ff && ((stopped && m_devsel_n_i) || mabort)) ||
                      lim_hit;
  assign dq_pop     = t_rel || dis_exp || m_drop_dly;
  assign serr_evt   = lim_hit || dis_exp;
  assign pw_pop     = (m_st_ff == M_IDLE && pw_hd_addr) ||
                      (xfer && !m_dly_ff) ||
                      (m_st_ff == M_DROP && post_rdy); // see R10

  // Attempts on the current delayed head
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) m_try_ff <= 33'h0_0000_0000;
    else if (dq_pop) m_try_ff <= 33'h0_0000_0000;
    else if (m_retry) m_try_ff <= m_try_ff + 33'h1; // see R15
  end

  // Master state machine; FRAME drops when the queue runs dry
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_st_ff    <= M_IDLE;
      m_addr_ff  <= 32'h0000_0000;
      m_cmd_ff   <= 4'h0;
      m_dly_ff   <= 1'b0;
      m_frame_ff <= 1'b0;
      m_lat_ff   <= 8'h00;
      m_dvw_ff   <= 3'h0;
    end else begin
      unique case (m_st_ff)
        M_IDLE: if (pw_hd_addr) begin
          m_addr_ff <= pw_hd.data;
          m_cmd_ff  <= pw_hd.cmd;
        end else if (m_start) begin
          m_dly_ff <= !post_rdy;
          m_st_ff  <= M_ADDR;
        end
        M_ADDR: begin
          m_frame_ff <= !m_dly_ff && pw_isdat(1); // see R12
          m_lat_ff   <= latency_timer_i;
          m_dvw_ff   <= 3'h0;
          m_st_ff    <= M_DATA;
        end
        M_DATA: begin
          if (m_lat_ff != 8'h00) m_lat_ff <= m_lat_ff - 8'h01;
          if (m_devsel_n_i && m_dvw_ff != `PBW_DEVSEL_WAIT) begin
            m_dvw_ff <= m_dvw_ff + 3'h1;
          end
          if (xfer) begin
            if (!m_dly_ff) m_addr_ff <= m_addr_ff + 32'h0000_0004;
            m_frame_ff <= pw_isdat(2) &&
                          !(m_lat_ff == 8'h00 && m_gnt_n_i); // see R9 see R10
            if (!m_frame_ff || stopped) m_st_ff <= M_TURN;
          end else if (stopped || mabort) begin
            m_st_ff <= (m_devsel_n_i && !m_dly_ff) ? M_DROP : M_TURN;
          end
        end
        M_DROP: if (!post_rdy) m_st_ff <= M_TURN;
        M_TURN: m_st_ff <= M_IDLE;
        default: m_st_ff <= M_IDLE;
      endcase
    end
  end

  // Master pins
  assign m_req_n_o   = !(m_st_ff == M_IDLE && (post_rdy || dly_rdy));
  assign m_ctl_oe_o  = m_st_ff == M_ADDR || m_st_ff == M_DATA ||
                       m_st_ff == M_TURN;
  assign m_ad_oe_o   = m_st_ff == M_ADDR || m_st_ff == M_DATA;
  assign m_frame_n_o = !(m_st_ff == M_ADDR ||
                         (m_st_ff == M_DATA && m_frame_ff));
  assign m_irdy_n_o  = m_st_ff != M_DATA;
  assign m_ad_o      = (m_st_ff == M_ADDR) ?
                       (m_dly_ff ? dq_hd.addr : m_addr_ff) :
                       (m_dly_ff ? dq_hd.data : pw_hd.data);
  assign m_cbe_n_o   = (m_st_ff == M_ADDR) ?
                       (m_dly_ff ? dq_hd.cmd : m_cmd_ff) :
                       ~(m_dly_ff ? dq_hd.be : pw_hd.be);

  // Target side answers
  a_devsel_medium: assert property ( // see R2
      t_take |=> t_devsel_n_o ##1 !t_devsel_n_o)
    else $error("devsel not at medium timing");
  a_trdy_after: assert property ( // see R5
      t_st_ff == T_CLAIM && t_post_ff && t_ok_ff |=>
      !t_trdy_n_o && !t_devsel_n_o)
    else $error("late trdy");
  a_no_room_retry: assert property ( // see R5
      t_st_ff == T_CLAIM && t_post_ff && !t_ok_ff |=>
      t_trdy_n_o && !t_stop_n_o)
    else $error("no room not retried");
  a_no_waits: assert property ( // see R6
      t_st_ff == T_POST && !t_irdy_n_i && !t_frame_n_i && !t_disc |=>
      !t_trdy_n_o)
    else $error("posted wait state");
  a_full_disc: assert property ( // see R7
      t_st_ff == T_POST && pw_free == 1 |-> !t_stop_n_o)
    else $error("full without disconnect");
  a_linear_only: assert property ( // see R1
      t_st_ff == T_POST && t_addr_ff[1:0] != 0 |-> !t_stop_n_o)
    else $error("misaligned not stopped");
  a_dly_repeat: assert property ( // see R19
      t_st_ff == T_DLY && !t_irdy_n_i && !t_comp |=>
      t_trdy_n_o && !t_stop_n_o)
    else $error("repeat not retried");
  a_dly_single: assert property ( // see R12
      t_st_ff == T_DCOMP && !t_frame_n_i |-> !t_stop_n_o && !t_trdy_n_o)
    else $error("delayed not single");
  // Master and error side; a repeat must never grow the delayed queue
  a_master_addr: assert property ( // see R8
      m_st_ff == M_ADDR |-> !m_frame_n_o ##1 (!m_irdy_n_o && m_ad_oe_o))
    else $error("data not after address");
  a_serr_pin: assert property ( // see R16
      serr_evt && serr_enable_i |=> primary_system_error_out_oe_o && serr_ff)
    else $error("system error not driven");
  a_dq_no_dup: assert property ( // see R14
      t_st_ff == T_DLY && !t_irdy_n_i && t_match |=>
      dq_cnt_ff <= $past(dq_cnt_ff))
    else $error("duplicate delayed entry");

endmodule

// File: tb/pbw_tgt_model.sv
`timescale 1ns/10ps
// Far-bus target: claims every address phase, retries the first few
module pbw_tgt_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic [31:0] ad_i,
  input  wire logic [1:0]  retries_i,
  output logic             devsel_n_o,
  output logic             trdy_n_o,
  output logic             stop_n_o,
  output logic [7:0]       words_o,
  output logic [31:0]      last_o
);
  logic       act_ff, rty_ff, fr_ff;
  logic [1:0] used_ff;
  // Idle lines read high, as the pull-ups would leave them
  assign devsel_n_o = !act_ff;
  assign trdy_n_o   = !(act_ff && !rty_ff);
  assign stop_n_o   = !(act_ff && rty_ff);
  // Claim on a fresh address phase, let go once the last phase ends
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {act_ff, rty_ff, used_ff, words_o, last_o} <= '0;
      fr_ff <= 1'b1;
    end else begin
      fr_ff <= frame_n_i;
      if (!frame_n_i && fr_ff && !act_ff) begin
        act_ff  <= 1'b1;
        rty_ff  <= (used_ff < retries_i);
        used_ff <= used_ff + 2'((used_ff < retries_i));
      end
      // A phase with STOP ends the burst; only IRDY with TRDY moves data
      if (act_ff && !irdy_n_i && (frame_n_i || rty_ff))
        act_ff <= 1'b0;
      if (act_ff && !irdy_n_i && !rty_ff) begin
        words_o <= words_o + 8'h01;
        last_o  <= ad_i;
      end
    end
  end
endmodule

// File: tb/pci_bridge_write_forwarding_tb.sv
`timescale 1ns/10ps
`include "pbw_cfg.svh"
module pci_bridge_write_forwarding_tb;
  import pbw_pkg::*;
  logic clk_i = 0, rst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, t_par_i = 0;
  logic t_frame_n_i = 1, t_irdy_n_i = 1, t_hit_i = 0, t_vga_hit_i = 0;
  logic serr_enable_i = 1, t_devsel_n_o, t_trdy_n_o, t_stop_n_o;
  logic t_ctl_oe_o, m_req_n_o, m_frame_n_o, m_irdy_n_o, m_ctl_oe_o;
  logic m_ad_oe_o, b_frame, b_irdy, p_devsel, p_trdy, p_stop;
  logic primary_system_error_out_n_o, primary_system_error_out_oe_o;
  logic [7:0]  cfg_addr_i = '0, cache_line_size_i = 8'h08, p_words;
  logic [7:0]  latency_timer_i = 8'h40;
  logic [31:0] cfg_wdata_i = '0, cfg_rdata_o, t_ad_i = '0, m_ad_o, p_last;
  logic [3:0]  t_cbe_n_i = '0, m_cbe_n_o;
  logic [1:0]  p_rty = '0;
  logic        gt, gs;
  int          dc, nw, bad_count = 0, num_checks = 0, cyc = 0, serr_n = 0;

  // Far bus lines float high whenever the bridge lets go of them
  assign b_frame = m_ctl_oe_o ? m_frame_n_o : 1'b1;
  assign b_irdy  = m_ctl_oe_o ? m_irdy_n_o : 1'b1;

  pbw_bridge #(.RETRY_LIMIT(33'h0_0000_0002)) dut (.*,
    .m_gnt_n_i(m_req_n_o), .m_frame_n_i(b_frame), .m_irdy_n_i(b_irdy),
    .m_trdy_n_i(p_trdy), .m_stop_n_i(p_stop), .m_devsel_n_i(p_devsel));
  pbw_tgt_model tgt (.clk_i(clk_i), .rst_i(rst_i), .frame_n_i(b_frame),
    .irdy_n_i(b_irdy), .ad_i(m_ad_o), .retries_i(p_rty),
    .devsel_n_o(p_devsel), .trdy_n_o(p_trdy), .stop_n_o(p_stop),
    .words_o(p_words), .last_o(p_last));

  always #12.5 clk_i = ~clk_i;

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Ceiling far above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  // Count system error pulses, each with the pin pulled low
  always @(negedge clk_i)
    serr_n += int'(primary_system_error_out_oe_o === 1'b1 &&
                   primary_system_error_out_n_o === 1'b0);

  task automatic cw(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i) {cfg_wr_i, cfg_addr_i, cfg_wdata_i} = {1'b1, a, d};
    @(negedge clk_i) cfg_wr_i = 0;
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk_i) {cfg_rd_i, cfg_addr_i} = {1'b1, a};
    @(negedge clk_i) cfg_rd_i = 0;
    chk(cfg_rdata_o, e);
  endtask

  // Initiator write burst of n words; data words count up from A5A50000
  task automatic wr(input logic [3:0] c, input logic [31:0] a, input int n);
    int cy;
    {gt, gs, dc, nw, cy} = '0;
    @(negedge clk_i) {t_frame_n_i, t_ad_i, t_cbe_n_i, t_hit_i} = {1'b0, a, c, 1'b1};
    @(negedge clk_i);
    {t_irdy_n_i, t_ad_i, t_cbe_n_i, t_hit_i} = {1'b0, 32'hA5A5_0000, 5'h0};
    t_frame_n_i = (n == 1);
    while (cy < 40) begin
      #10 cy++; // Just ahead of the edge, once the lines have settled
      if (dc == 0 && t_ctl_oe_o === 1 && t_devsel_n_o === 0) dc = cy;
      if (t_ctl_oe_o === 1 && (t_trdy_n_o === 0 || t_stop_n_o === 0)) begin
        gt |= !t_trdy_n_o;
        gs |= !t_stop_n_o;
        nw += int'(!t_trdy_n_o);
        @(negedge clk_i);
        if (gs || nw == n) begin
          if (!t_frame_n_i) begin
            t_frame_n_i = 1;
            @(negedge clk_i);
          end
          t_irdy_n_i = 1;
          t_ad_i = ~t_ad_i;
          cy = 99;
        end else begin
          t_ad_i++;
          t_frame_n_i = (nw == n - 1);
        end
      end else begin
        @(negedge clk_i);
      end
    end
  endtask

  // Give the far side a bounded time to collect w words in all
  task automatic wt(input int w);
    for (int i = 0; i < 300 && p_words < w; i++) @(negedge clk_i);
  endtask

  task automatic t_regs;
    cr(`PBW_DRC_OFS, `PBW_DRC_RST);
    cw(`PBW_DRC_OFS, 32'h0000_0040);
    cr(`PBW_DRC_OFS, 32'h0000_0040);
    cw(`PBW_CHIP_CTRL_OFS, 32'h0000_0002);
    cr(`PBW_CHIP_CTRL_OFS, 32'h0000_0002);
    cw(`PBW_CHIP_CTRL_OFS, 32'h0);
    cr(8'h10, 32'h0);
  endtask

  task automatic t_post;
    wr(PBW_MEM_WR, 32'h0000_1000, 2);
    chk({gt, gs, nw[3:0]}, 6'h22);
    chk(dc, 2);
    wt(2);
    chk({p_words, p_last}, {8'h02, 32'hA5A5_0001});
  endtask

  task automatic t_mis;
    wr(PBW_MEM_WR, 32'h0000_2001, 2);
    chk({gt, gs, nw[3:0]}, 6'h31);
    wt(3);
    chk({p_words, p_last}, {8'h03, 32'hA5A5_0000});
  endtask

  task automatic t_dly;
    p_rty = 2'h1;
    wr(PBW_IO_WR, 32'h0000_0100, 1);
    chk({gt, gs, dc[3:0]}, 6'h12);
    wt(4);
    chk({p_words, p_last}, {8'h04, 32'hA5A5_0000});
    wr(PBW_IO_WR, 32'h0000_0100, 2);
    chk({gt, gs, nw[3:0]}, 6'h31);
  endtask

  // Retry limit drop, then an unclaimed completion left to expire
  task automatic t_err;
    p_rty = 2'h3;
    wr(PBW_IO_WR, 32'h0000_0300, 1);
    repeat (30) @(negedge clk_i);
    chk({gs, serr_n[3:0], p_words}, {1'b1, 4'h1, 8'h04});
    cr(`PBW_STATUS_OFS, 32'h0000_0001);
    cw(`PBW_STATUS_OFS, 32'h0000_0001);
    wr(PBW_IO_WR, 32'h0000_0200, 1);
    repeat (90) @(negedge clk_i);
    chk({gs, serr_n[3:0], p_words}, {1'b1, 4'h2, 8'h05});
    cr(`PBW_STATUS_OFS, 32'h0000_0001);
  endtask

  initial begin
    #50 rst_i = 0;
    t_regs;
    t_post;
    t_mis;
    t_dly;
    t_err;
    tally_and_finish;
  end
endmodule
